// ---- rtl/link_partner_ability_capture.sv ----
// Link partner ability register with APB access and interrupts.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "lpa_defines.svh"
module link_partner_ability_capture
    import lpa_pkg::*;
(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave.
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Negotiation engine, same clock.
    input  wire logic             cw_valid,
    input  wire lpa_pkg::mii_word_t cw_data,
    input  wire logic             an_restart_req,
    input  wire logic             pd_link_up,
    input  wire logic             pd_is_100,
    input  wire logic             link_lost,
    // Control out to the engine.
    output logic                  an_enable,
    output logic                  an_restart,
    // Interrupt.
    output logic                  irq
);
    import lpa_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    apb_state_t   st_r;          // Bus answer state.
    apb_state_t   st_nxt;        // Next bus answer state.
    logic [31:0]  prdata_nxt;    // Read data to present.
    logic         pready_nxt;    // Next ready.
    logic         pslverr_nxt;   // Next error.
    logic         an_enable_r;   // Software negotiation enable.
    logic         an_enable_nxt; // Next enable.
    logic         restart_r;     // Software restart pulse.
    logic         restart_nxt;   // Next restart pulse.
    logic         page_rx_r;     // Page received flag.
    logic         page_rx_nxt;   // Next page received flag.
    logic         acc;           // Transfer completes this edge.
    logic         wr_acc;        // Write completes this edge.
    logic         rd_acc;        // Read completes this edge.
    logic [5:0]   idx;           // Word index of the address.
    logic         mapped;        // Address hits a register.
    logic         restart_all;   // Any restart source.
    mii_word_t    ability;       // Stored partner word.
    logic         lp_an_able;    // Partner negotiated.
    logic         an_done;       // Negotiation finished.
    logic [`LPA_EV_COUNT-1:0] events;     // Event pulses.
    logic [`LPA_EV_COUNT-1:0] irq_status; // Sticky status.
    logic [`LPA_EV_COUNT-1:0] irq_enable; // Interrupt mask.
    logic         irq_int;       // Interrupt from the collector.

    // Byte address of the ability word, used by the checks.
    localparam logic [7:0] ABILITY_ADDR = {`LPA_IDX_ABILITY, 2'b00};

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle, and
    // every write and read side effect happens only at that edge.
    always_comb begin
        idx    = paddr[7:2];
        acc    = psel & penable & pready;
        wr_acc = acc & pwrite;
        rd_acc = acc & ~pwrite;
        case (idx)
            `LPA_IDX_BSTAT,
            `LPA_IDX_ABILITY,
            `LPA_IDX_EXPAND,
            `LPA_IDX_CTRL,
            `LPA_IDX_IRQ_STAT,
            `LPA_IDX_IRQ_EN,
            `LPA_IDX_IRQ_CLR: mapped = 1'b1;
            default:          mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Answer sequencing and read mux
    // ------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata;
        case (st_r)
            ST_IDLE: begin
                // Access phase seen: build the answer for next edge.
                if (psel && penable) begin
                    st_nxt      = ST_ANSWER;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = ~mapped;
                    prdata_nxt  = 32'h0000_0000;
                    if (!pwrite) begin
                        case (idx)
                            `LPA_IDX_BSTAT: begin
                                // Completion flag software waits on.
                                prdata_nxt[`LPA_BIT_AN_DONE] = an_done;
                            end
                            `LPA_IDX_ABILITY: begin
                                // Reserved pair reads zero.
                                prdata_nxt[15:0] = ability;
                            end
                            `LPA_IDX_EXPAND: begin
                                prdata_nxt[`LPA_BIT_LP_NEXT_PAGE] =
                                    ability[`LPA_BIT_MORE_PAGES];
                                prdata_nxt[`LPA_BIT_PAGE_RX]    = page_rx_r;
                                prdata_nxt[`LPA_BIT_LP_AN_ABLE] = lp_an_able;
                            end
                            `LPA_IDX_CTRL: begin
                                prdata_nxt[`LPA_BIT_AN_ENABLE] = an_enable_r;
                            end
                            `LPA_IDX_IRQ_STAT: begin
                                prdata_nxt[`LPA_EV_COUNT-1:0] = irq_status;
                            end
                            `LPA_IDX_IRQ_EN: begin
                                prdata_nxt[`LPA_EV_COUNT-1:0] = irq_enable;
                            end
                            default: begin
                                // Clear register and holes read zero.
                                prdata_nxt = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            ST_ANSWER: begin
                // Transfer ends here; ready drops for the next one.
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r    <= ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            st_r    <= st_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata  <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Control register and page received flag
    // ------------------------------------------------------------
    // Writes to the ability index match no condition here, so the
    // stored word changes from the bus only through a control restart.
    always_comb begin
        an_enable_nxt = an_enable_r;
        restart_nxt   = 1'b0;
        page_rx_nxt   = page_rx_r;
        if (wr_acc && idx == `LPA_IDX_CTRL) begin
            an_enable_nxt = pwdata[`LPA_BIT_AN_ENABLE];
            restart_nxt   = pwdata[`LPA_BIT_AN_RESTART];
        end
        // Clear on ability read or lost link; a new page wins.
        if ((rd_acc && idx == `LPA_IDX_ABILITY) || link_lost) begin
            page_rx_nxt = 1'b0;
        end
        if (cw_valid) begin
            page_rx_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_enable_r <= `LPA_AN_ENABLE_RESET;
            restart_r   <= 1'b0;
            page_rx_r   <= 1'b0;
            an_enable   <= `LPA_AN_ENABLE_RESET;
            an_restart  <= 1'b0;
            irq         <= 1'b0;
        end else begin
            an_enable_r <= an_enable_nxt;
            restart_r   <= restart_nxt;
            page_rx_r   <= page_rx_nxt;
            an_enable   <= an_enable_nxt;
            an_restart  <= restart_nxt;
            irq         <= irq_int;
        end
    end

    // ------------------------------------------------------------
    // Word storage and interrupts
    // ------------------------------------------------------------
    always_comb begin
        restart_all = restart_r | an_restart_req;
        events      = '0;
        events[`LPA_EV_PAGE]   = cw_valid;
        events[`LPA_EV_PARDET] = pd_link_up & an_enable_r;
        // Fault is recorded in status and can raise irq; an_enable and an_restart do not react to it.
        events[`LPA_EV_RFAULT] = cw_valid &
                                 cw_data[`LPA_BIT_REMOTE_FAULT];
    end

    lpa_word_store u_store (
        .pclk       (pclk),
        .presetn    (presetn),
        .cw_valid   (cw_valid),
        .cw_data    (cw_data),
        .restart    (restart_all),
        .pd_link_up (pd_link_up),
        .pd_is_100  (pd_is_100),
        .an_enable  (an_enable_r),
        .ability    (ability),
        .lp_an_able (lp_an_able),
        .an_done    (an_done)
    );

    lpa_irq #(.N(`LPA_EV_COUNT)) u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .events  (events),
        .en_wr   (wr_acc && idx == `LPA_IDX_IRQ_EN),
        .clr_wr  (wr_acc && idx == `LPA_IDX_IRQ_CLR),
        .wdata   (pwdata[`LPA_EV_COUNT-1:0]),
        .status  (irq_status),
        .enable  (irq_enable),
        .irq     (irq_int)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_copy_upper: assert property (@(posedge pclk) disable iff (!presetn)
        cw_valid |=> ability[15:13] == $past(cw_data[15:13]))
        else $error("upper ability bits not copied");
    a_copy_ability: assert property (@(posedge pclk) disable iff (!presetn)
        cw_valid |=> ability[10:0] == $past(cw_data[10:0]))
        else $error("ability or selector not copied");
    a_restart_clear: assert property (@(posedge pclk) disable iff (!presetn)
        an_restart_req && !cw_valid && !pd_link_up
        |=> ability == 16'h0000)
        else $error("restart did not clear ability");
    a_pd_fast: assert property (@(posedge pclk) disable iff (!presetn)
        pd_link_up && an_enable_r && pd_is_100 && !cw_valid
        |=> ability[`LPA_BIT_FAST_HD] && !lp_an_able)
        else $error("parallel detect 100 not recorded");
    a_pd_ten: assert property (@(posedge pclk) disable iff (!presetn)
        pd_link_up && an_enable_r && !pd_is_100 && !cw_valid
        |=> ability[`LPA_BIT_TEN_HD] && an_done)
        else $error("parallel detect 10 not recorded");
    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ABILITY_ADDR && !cw_valid
        |=> !page_rx_r)
        else $error("ability read kept page received");
    a_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == ABILITY_ADDR && !cw_valid && !restart_all
        && !pd_link_up |=> $stable(ability))
        else $error("write changed ability");
    a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ability[12:11] == 2'h0)
        else $error("reserved ability bits set");
    a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready not one cycle after one wait");
    // Page flag, fault event and interrupt level follow their flops,
    // so a broken set path or a lost flop stage shows up here.
    a_page_set: assert property (@(posedge pclk) disable iff (!presetn)
        cw_valid |=> page_rx_r)
        else $error("received page not flagged");
    a_fault_event: assert property (@(posedge pclk) disable iff (!presetn)
        cw_valid && cw_data[`LPA_BIT_REMOTE_FAULT]
        |=> irq_status[`LPA_EV_RFAULT])
        else $error("remote fault event not recorded");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == $past(|(irq_status & irq_enable)))
        else $error("interrupt level does not follow status");
    a_restart_once: assert property (@(posedge pclk) disable iff (!presetn)
        an_restart |=> !an_restart)
        else $error("restart pulse longer than one cycle");
endmodule

// ---- rtl/lpa_defines.svh ----
// Register indexes, field positions, reset values for the partner ability.
`ifndef LPA_DEFINES_SVH
`define LPA_DEFINES_SVH

// Register indexes; the byte address is four times the index.
`define LPA_IDX_BSTAT    6'h01
`define LPA_IDX_ABILITY  6'h05
`define LPA_IDX_EXPAND   6'h06
`define LPA_IDX_CTRL     6'h08
`define LPA_IDX_IRQ_STAT 6'h09
`define LPA_IDX_IRQ_EN   6'h0A
`define LPA_IDX_IRQ_CLR  6'h0B

// Partner ability word fields.
`define LPA_BIT_MORE_PAGES   15
`define LPA_BIT_ACK          14
`define LPA_BIT_REMOTE_FAULT 13
`define LPA_BIT_PAUSE        10
`define LPA_BIT_FOUR_PAIR    9
`define LPA_BIT_FAST_FD      8
`define LPA_BIT_FAST_HD      7
`define LPA_BIT_TEN_FD       6
`define LPA_BIT_TEN_HD       5
`define LPA_SEL_MSB          4
`define LPA_ABILITY_RESET    16'h0000

// Basic status, expansion and control fields.
`define LPA_BIT_AN_DONE      5
`define LPA_BIT_LP_NEXT_PAGE 3
`define LPA_BIT_PAGE_RX      1
`define LPA_BIT_LP_AN_ABLE   0
`define LPA_BIT_AN_ENABLE    0
`define LPA_BIT_AN_RESTART   1
`define LPA_AN_ENABLE_RESET  1'h1

// Interrupt event positions.
`define LPA_EV_PAGE   0
`define LPA_EV_PARDET 1
`define LPA_EV_RFAULT 2
`define LPA_EV_COUNT  3

`endif

// ---- rtl/lpa_irq.sv ----
// Sticky event status, enable mask and level interrupt.
`timescale 1ns/100ps
module lpa_irq #(
    parameter int N = 3
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Events, one-cycle pulses.
    input  wire logic [N-1:0] events,
    // Software access.
    input  wire logic         en_wr,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] wdata,
    // State.
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);
    logic [N-1:0] status_nxt; // Next sticky bits.
    logic [N-1:0] enable_nxt; // Next mask.
    logic         irq_nxt;    // Next interrupt level.

    // Elaboration check: the status bits must fit one bus word.
    if (N < 1 || N > 32) begin : g_bad_n
        $error("lpa_irq: N out of range");
    end

    // ------------------------------------------------------------
    // Sticky bits
    // ------------------------------------------------------------
    // An event in the clearing cycle keeps its bit set.
    for (genvar i = 0; i < N; i++) begin : g_bit
        always_comb begin
            status_nxt[i] = events[i] | (status[i] & ~(clr_wr & wdata[i]));
        end
    end

    always_comb begin
        enable_nxt = en_wr ? wdata : enable;
        irq_nxt    = |(status_nxt & enable_nxt);
    end

    // Interrupt is a flop so it follows status in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            enable <= '0;
            irq    <= 1'b0;
        end else begin
            status <= status_nxt;
            enable <= enable_nxt;
            irq    <= irq_nxt;
        end
    end
endmodule

// ---- rtl/lpa_pkg.sv ----
// Types shared by the partner ability capture block.
package lpa_pkg;
    // One management word.
    typedef logic [15:0] mii_word_t;
    // Bus answer sequencing.
    typedef enum logic {ST_IDLE, ST_ANSWER} apb_state_t;
endpackage

// ---- rtl/lpa_word_store.sv ----
// Storage of the partner ability word and its completion flags.
`timescale 1ns/100ps
`include "lpa_defines.svh"
module lpa_word_store
    import lpa_pkg::*;
(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Events from the negotiation engine.
    input  wire logic             cw_valid,
    input  wire lpa_pkg::mii_word_t cw_data,
    input  wire logic             restart,
    input  wire logic             pd_link_up,
    input  wire logic             pd_is_100,
    input  wire logic             an_enable,
    // Stored state.
    output lpa_pkg::mii_word_t    ability,
    output logic                  lp_an_able,
    output logic                  an_done
);
    mii_word_t ability_nxt;   // Next ability word.
    logic      lp_an_able_nxt; // Next partner-can-negotiate flag.
    logic      an_done_nxt;    // Next completion flag.

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A new word or detection wins over a restart in the same cycle,
    // so an event is never lost to the clear.
    always_comb begin
        ability_nxt    = ability;
        lp_an_able_nxt = lp_an_able;
        an_done_nxt    = an_done;
        if (restart) begin
            ability_nxt    = `LPA_ABILITY_RESET;
            lp_an_able_nxt = 1'b0;
            an_done_nxt    = 1'b0;
        end
        if (cw_valid) begin
            // Whole word copied, reserved pair forced to zero.
            ability_nxt        = cw_data;
            ability_nxt[12:11] = 2'h0;
            lp_an_able_nxt     = 1'b1;
            an_done_nxt        = 1'b1;
        end else if (pd_link_up && an_enable) begin
            // Partner cannot negotiate: record the detected speed.
            if (pd_is_100) begin
                ability_nxt[`LPA_BIT_FAST_HD] = 1'b1;
            end else begin
                ability_nxt[`LPA_BIT_TEN_HD] = 1'b1;
            end
            lp_an_able_nxt = 1'b0;
            an_done_nxt    = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ability    <= `LPA_ABILITY_RESET;
            lp_an_able <= 1'b0;
            an_done    <= 1'b0;
        end else begin
            ability    <= ability_nxt;
            lp_an_able <= lp_an_able_nxt;
            an_done    <= an_done_nxt;
        end
    end
endmodule

// ---- testbench/link_partner_ability_capture_tb.sv ----
// Self-checking bench for the partner ability capture block.
`timescale 1ns/100ps
`include "lpa_defines.svh"
module link_partner_ability_capture_tb;
    import lpa_pkg::*;
    // ------------------------------------------------------------
    // Addresses, table and signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_BST = {`LPA_IDX_BSTAT, 2'b00};
    localparam logic [7:0] A_ABL = {`LPA_IDX_ABILITY, 2'b00};
    localparam logic [7:0] A_EXP = {`LPA_IDX_EXPAND, 2'b00};
    localparam logic [7:0] A_CTL = {`LPA_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_IRS = {`LPA_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_IEN = {`LPA_IDX_IRQ_EN, 2'b00};
    localparam logic [7:0] A_ICL = {`LPA_IDX_IRQ_CLR, 2'b00};
    // Reserved bits 12:11 read zero; ability reads still mask them.
    localparam logic [31:0] AM = 32'hFFFFE7FF;
    typedef struct packed {
        mii_word_t   w;
        logic [31:0] exp;
    } row_t;
    // Received word beside the ability read that it must give.
    row_t rows [0:10] = '{
        {16'h8001, 32'h8001}, {16'h4001, 32'h4001},
        {16'h2001, 32'h2001}, {16'h0401, 32'h0401},
        {16'h0201, 32'h0201}, {16'h0101, 32'h0101},
        {16'h0081, 32'h0081}, {16'h0041, 32'h0041},
        {16'h0021, 32'h0021}, {16'h001F, 32'h001F},
        {16'hFFFF, 32'hE7FF}};
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, e, an_enable, an_restart, irq;
    logic        cw_valid, an_restart_req, pd_link_up, pd_is_100;
    logic        link_lost;
    mii_word_t   cw_data;
    int          miscompares = 0;
    int          n_compared = 0;
    int          n_rst = 0;

    link_partner_ability_capture dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cw_valid(cw_valid), .cw_data(cw_data),
        .an_restart_req(an_restart_req), .pd_link_up(pd_link_up),
        .pd_is_100(pd_is_100), .link_lost(link_lost),
        .an_enable(an_enable), .an_restart(an_restart), .irq(irq));
    link_partner_model lp (.pclk(pclk), .cw_valid(cw_valid),
        .cw_data(cw_data), .an_restart_req(an_restart_req),
        .pd_link_up(pd_link_up), .pd_is_100(pd_is_100),
        .link_lost(link_lost));

    // ------------------------------------------------------------
    // Clock, restart pulse counter and helpers
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Counts restart pulses handed to the engine.
    always @(posedge pclk) begin
        if (an_restart === 1'b1) n_rst <= n_rst + 1;
    end

    // Masked compare that reports and counts.
    task automatic chk(input logic [31:0] got, exp, m);
        n_compared++;
        if ((got & m) !== exp) begin
            miscompares++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, the watchdog bounds it.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read one register and compare it under a mask.
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
        apb(1'b0, a, 32'h0);
        chk({31'h0, e}, 32'h0, 32'h1);
        chk(r, x, m);
    endtask

    // Verdict; the only place that ends the run.
    task automatic close_out();
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_ABL, 32'h0, AM);
        rd(A_CTL, 32'h1, 32'hFFFFFFFF);
        chk({31'h0, irq}, 32'h0, 32'h1);
        // Table: word in, status, expansion, ability, read clear.
        foreach (rows[i]) begin
            lp.send_word(rows[i].w);
            rd(A_BST, 32'h20, 32'h20);
            rd(A_EXP, {28'h0, rows[i].w[15], 3'b011}, '1);
            rd(A_ABL, rows[i].exp, AM);
            rd(A_EXP, {28'h0, rows[i].w[15], 3'b001}, '1);
        end
        // Writes to the ability register change nothing.
        apb(1'b1, A_ABL, 32'h0);
        chk({31'h0, e}, 32'h0, 32'h1);
        rd(A_ABL, 32'hE7FF, AM);
        // Engine restart clears word and completion.
        lp.line_event(1'b1, 1'b0);
        rd(A_ABL, 32'h0, AM);
        rd(A_BST, 32'h0, 32'h20);
        // Software restart: one pulse out, word cleared, bit reads 0.
        lp.send_word(16'h03E1);
        apb(1'b1, A_CTL, 32'h3);
        rd(A_ABL, 32'h0, AM);
        chk(n_rst, 32'h1, '1);
        rd(A_CTL, 32'h1, '1);
        // Parallel detection at each speed, then with it disabled.
        lp.par_detect(1'b1);
        rd(A_ABL, 32'h0080, AM);
        lp.par_detect(1'b0);
        rd(A_ABL, 32'h00A0, AM);
        rd(A_EXP, 32'h0, 32'h1);
        apb(1'b1, A_CTL, 32'h0);
        @(posedge pclk);
        chk({31'h0, an_enable}, 32'h0, 32'h1);
        lp.line_event(1'b1, 1'b0);
        lp.par_detect(1'b1);
        rd(A_ABL, 32'h0, AM);
        apb(1'b1, A_CTL, 32'h1);
        // Interrupts: clear, mask, raise, clear again.
        apb(1'b1, A_ICL, 32'h7);
        rd(A_IRS, 32'h0, '1);
        apb(1'b1, A_IEN, 32'h5);
        lp.par_detect(1'b1);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        rd(A_IRS, 32'h2, '1);
        lp.send_word(16'h2001);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rd(A_IRS, 32'h7, '1);
        rd(A_IEN, 32'h5, '1);
        apb(1'b1, A_ICL, 32'h7);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        rd(A_IRS, 32'h0, '1);
        // Link loss drops page received.
        lp.send_word(16'h0021);
        lp.line_event(1'b0, 1'b1);
        rd(A_EXP, 32'h0, 32'h2);
        // Unmapped address answers with an error and zero.
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, e}, 32'h1, 32'h1);
        chk(r, 32'h0, '1);
        // Reset in mid-run restores ability, interrupt enable and control.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_ABL, 32'h0, AM);
        rd(A_IEN, 32'h0, '1);
        rd(A_CTL, 32'h1, '1);
        close_out();
    end
endmodule

// ---- testbench/link_partner_model.sv ----
// Behavioural remote link partner driving the negotiation inputs.
`timescale 1ns/100ps
module link_partner_model
    import lpa_pkg::*;
(
    // Clock.
    input  wire logic           pclk,
    // Results of negotiation towards the block.
    output logic                cw_valid,
    output lpa_pkg::mii_word_t  cw_data,
    output logic                an_restart_req,
    output logic                pd_link_up,
    output logic                pd_is_100,
    output logic                link_lost
);
    // Idle levels; the data lines carry junk outside a pulse.
    initial begin
        cw_valid       = 1'b0;
        cw_data        = 16'h5A5A;
        an_restart_req = 1'b0;
        pd_link_up     = 1'b0;
        pd_is_100      = 1'b0;
        link_lost      = 1'b0;
    end

    // One received code word; data is inverted after so a stale
    // capture cannot pass for a fresh one.
    task automatic send_word(input mii_word_t w);
        @(posedge pclk);
        cw_data  <= w;
        cw_valid <= 1'b1;
        @(posedge pclk);
        cw_valid <= 1'b0;
        cw_data  <= ~w;
    endtask

    // Link brought up by parallel detection at one speed.
    task automatic par_detect(input logic fast);
        @(posedge pclk);
        pd_is_100  <= fast;
        pd_link_up <= 1'b1;
        @(posedge pclk);
        pd_link_up <= 1'b0;
        pd_is_100  <= ~fast;
    endtask

    // Engine restart request and/or link loss, one cycle each.
    task automatic line_event(input logic rst, input logic lost);
        @(posedge pclk);
        an_restart_req <= rst;
        link_lost      <= lost;
        @(posedge pclk);
        an_restart_req <= 1'b0;
        link_lost      <= 1'b0;
    endtask
endmodule
